//--- rtl/see_cfg.svh
// constants of the two-wire eeprom engine: field values and timing counts
`ifndef SEE_CFG_SVH
`define SEE_CFG_SVH
// fixed upper nibble of the device address word
`define SEE_DEV_TYPE 4'ha
// bit counter values inside one nine-clock word
`define SEE_LAST_BIT 4'h7
`define SEE_ACK_BIT 4'h8
// system clock and serial clock rates
`define SEE_SYS_KHZ 50000
`define SEE_SCL_KHZ 400
// quarter of a serial clock period, rounded up so the bus runs no faster
`define SEE_QTR_CYC ((`SEE_SYS_KHZ + 4 * `SEE_SCL_KHZ - 1) / (4 * `SEE_SCL_KHZ))
// self-timed write interval in ms and in system cycles
`define SEE_TWR_MS 5
`define SEE_TWR_CYC (`SEE_TWR_MS * `SEE_SYS_KHZ)
// reset levels of the link
`define SEE_SCL_RST 1'b1
`define SEE_DRV_RST 1'b0
`endif

//--- rtl/see_pkg.sv
// types shared by both ends of the two-wire eeprom link
package see_pkg;
  // array size select, 2k / 4k / 8k / 16k
  typedef enum logic [1:0] {SEE_D2K, SEE_D4K, SEE_D8K, SEE_D16K} see_dens_t;
  // device link states
  typedef enum logic [2:0] {SEE_S_IDLE, SEE_S_ADDR, SEE_S_WORD, SEE_S_WDATA, SEE_S_RDATA,
    SEE_S_HOLD} see_dst_t;
  // master primitive commands
  typedef enum logic [1:0] {SEE_OP_START, SEE_OP_WRITE, SEE_OP_READ, SEE_OP_STOP} see_op_t;
  // master sequencer states
  typedef enum logic [1:0] {SEE_M_IDLE, SEE_M_START, SEE_M_BIT, SEE_M_STOP} see_mst_t;

  // device state clocked by the serial clock
  typedef struct packed {
    see_dst_t st;
    logic [3:0] cnt;
    logic [7:0] sh;
    logic [2:0] pg;
    logic drv;
    logic rw;
    logic [10:0] ctr;
    logic [10:0] waddr;
    logic [7:0] wdata;
    logic wtgl;
  } see_dlink_t;

  // device state clocked by the system clock
  typedef struct packed {
    logic [17:0] tmr;
    logic busy;
    logic wrote;
    logic sclp;
    logic sdap;
    logic tglp;
    logic we;
    logic [10:0] wa;
    logic [7:0] wd;
  } see_dsys_t;

  // master state
  typedef struct packed {
    see_mst_t st;
    logic [1:0] ph;
    logic [5:0] qc;
    logic [3:0] bn;
    logic [8:0] sh;
    logic [8:0] rx;
    logic scl;
    logic sdl;
    logic rv;
    logic [7:0] rd;
    logic nk;
  } see_mstate_t;
endpackage : see_pkg

//--- rtl/see_if.sv
// two-wire link between master and eeprom device, open-drain data line
`timescale 1ns/1ps
`default_nettype none
interface see_if;
  logic scl;
  logic m_sda_out;
  logic m_sda_oe;
  logic d_sda_out;
  logic d_sda_oe;
  logic sda;
  // wired-and of both drivers with the pull-up
  assign sda = !(m_sda_oe && !m_sda_out) && !(d_sda_oe && !d_sda_out);
  modport master (output scl, output m_sda_out, output m_sda_oe, input sda);
  modport device (input scl, output d_sda_out, output d_sda_oe, input sda);
endinterface : see_if
`default_nettype wire

//--- rtl/see_sync.sv
// two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module see_sync #(
  parameter int W = 1
) (
  input wire logic clk_in, // destination clock
  input wire logic rst_b_in, // synchronous reset, active low
  input wire logic [W-1:0] d_in, // foreign level
  output logic [W-1:0] q_out // level in clk_in domain
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } see_sync_st_t;
  see_sync_st_t st_q;
  see_sync_st_t st_d;

  // first stage feeds only the second
  always_comb
  begin
    st_d.s1 = d_in;
    st_d.s2 = st_q.s1;
  end

  always_ff @(posedge clk_in)
  begin
    if (!rst_b_in)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign q_out = st_q.s2;
endmodule : see_sync
`default_nettype wire

//--- rtl/see_dev.sv
// eeprom device end: address decode, writes, reads and self-timed write
// Overview of operation
// [R1] sda falling with scl high is start
// [R2] sda rising with scl high is stop
// [R3] data changes only while scl low
// [R4] eight-bit words, receiver acks on ninth clock
// [R5] device word opens with fixed 1010 nibble
// [R6] 2k compares all three select pins
// [R7] 4k compares two pins, third bit pages
// [R8] 8k compares one pin, two page bits
// [R9] 16k compares no select pins
// [R10] low address bit: one reads, zero writes
// [R11] ack on match, else standby until start
// [R12] byte write: device, word, data, stop
// [R13] after write stop, timed busy, no ack
// [R14] page is 8 bytes 2k, else 16
// [R15] page write continues bytes until stop
// [R16] only low page bits increment and wrap
// [R17] polling acked only after write done
// [R18] counter keeps last address plus one
// [R19] reads wrap whole array, writes wrap page
// [R20] current read outputs byte at counter
// [R21] random read uses dummy write first
// [R22] master ack continues reading, nack ends
// [R23] release sda for master ack slot
`timescale 1ns/1ps
`default_nettype none
`include "see_cfg.svh"
module see_dev #(
  parameter int TWR_CYC = `SEE_TWR_CYC
) (
  input wire logic clk_sys_in, // system clock, 50 mhz
  input wire logic rst_b_in, // reset, active low
  see_if.device link, // two-wire link
  input wire see_pkg::see_dens_t density_in, // array size strap
  input wire logic chip_select_pin_two_in, // hard-wired select pin 2
  input wire logic chip_select_pin_one_in, // hard-wired select pin 1
  input wire logic chip_select_pin_zero_in, // hard-wired select pin 0
  input wire logic [7:0] mem_rdata_in, // array byte at mem_addr_out
  output logic [10:0] mem_addr_out, // address counter
  output logic mem_we_out, // one-cycle array write strobe
  output logic [10:0] mem_waddr_out, // write address
  output logic [7:0] mem_wdata_out, // write data
  output logic busy_out // self-timed write running
);
  see_pkg::see_dlink_t ln_q;
  see_pkg::see_dlink_t ln_d;
  see_pkg::see_dsys_t sy_q;
  see_pkg::see_dsys_t sy_d;
  logic sda_rise_q;
  logic [13:0] lk_s;
  logic [2:0] sy_s;
  logic lk_busy;
  see_pkg::see_dens_t lk_dens;
  logic [2:0] lk_cs;
  logic [7:0] lk_rdata;
  logic [7:0] byte_v;
  logic load;
  logic stop_v;
  logic start_v;

  // address word select bits against the pins, per density
  function automatic logic cs_match(see_pkg::see_dens_t d, logic [2:0] b, logic [2:0] p);
    unique case (d)
      see_pkg::SEE_D2K: cs_match = (b == p); // R6
      see_pkg::SEE_D4K: cs_match = (b[2:1] == p[2:1]); // R7
      see_pkg::SEE_D8K: cs_match = (b[2] == p[2]); // R8
      see_pkg::SEE_D16K: cs_match = 1'b1; // R9
    endcase
  endfunction : cs_match

  // word address load with page bits from the device word
  function automatic logic [10:0] addr_load(see_pkg::see_dens_t d, logic [2:0] pg,
    logic [7:0] w);
    unique case (d)
      see_pkg::SEE_D2K: addr_load = {3'h0, w};
      see_pkg::SEE_D4K: addr_load = {2'h0, pg[0], w}; // R7
      see_pkg::SEE_D8K: addr_load = {1'b0, pg[1:0], w}; // R8
      see_pkg::SEE_D16K: addr_load = {pg, w};
    endcase
  endfunction : addr_load

  // read increment wraps over the whole array
  function automatic logic [10:0] read_next(see_pkg::see_dens_t d, logic [10:0] a);
    unique case (d)
      see_pkg::SEE_D2K: read_next = {3'h0, a[7:0] + 8'h01}; // R19
      see_pkg::SEE_D4K: read_next = {2'h0, a[8:0] + 9'h001};
      see_pkg::SEE_D8K: read_next = {1'b0, a[9:0] + 10'h001};
      see_pkg::SEE_D16K: read_next = a + 11'h001;
    endcase
  endfunction : read_next

  // write increment wraps inside the page
  function automatic logic [10:0] page_next(see_pkg::see_dens_t d, logic [10:0] a);
    if (d == see_pkg::SEE_D2K)
      page_next = {a[10:3], a[2:0] + 3'h1}; // R14 R16
    else
      page_next = {a[10:4], a[3:0] + 4'h1}; // R14 R16
  endfunction : page_next

  // straps, array data and busy brought onto the serial clock
  see_sync #(.W(14)) u_lk_sync (
    .clk_in(link.scl),
    .rst_b_in(rst_b_in),
    .d_in({sy_q.busy, density_in, chip_select_pin_two_in, chip_select_pin_one_in,
      chip_select_pin_zero_in, mem_rdata_in}),
    .q_out(lk_s)
  );
  assign lk_busy = lk_s[13];
  assign lk_dens = see_pkg::see_dens_t'(lk_s[12:11]);
  assign lk_cs = lk_s[10:8];
  assign lk_rdata = lk_s[7:0];

  // data sampled at the rising serial clock edge; a rising data line sets it too,
  // since after a stop the clock stays high and a new start brings no rising edge
  always_ff @(posedge link.scl or posedge link.sda or negedge rst_b_in)
  begin
    if (!rst_b_in)
      sda_rise_q <= 1'b1;
    else if (link.sda)
      sda_rise_q <= 1'b1; // R1 R2
    else
      sda_rise_q <= 1'b0; // R3
  end

  assign byte_v = {ln_q.sh[6:0], sda_rise_q};

  // link sequencer, steps on each falling serial clock edge
  always_comb
  begin
    ln_d = ln_q;
    load = 1'b0;
    if (sda_rise_q && !link.sda)
    begin
      // sda fell while scl stayed high: a (repeated) start
      ln_d.st = see_pkg::SEE_S_ADDR; // R1
      ln_d.cnt = 4'h0;
      ln_d.drv = 1'b0;
    end
    else if (!sda_rise_q && link.sda)
    begin
      ln_d.st = see_pkg::SEE_S_IDLE; // R2
      ln_d.cnt = 4'h0;
      ln_d.drv = 1'b0;
    end
    else
    begin
      unique case (ln_q.st)
        see_pkg::SEE_S_IDLE, see_pkg::SEE_S_HOLD:
        begin
          ln_d.drv = 1'b0; // R23
        end
        see_pkg::SEE_S_ADDR, see_pkg::SEE_S_WORD, see_pkg::SEE_S_WDATA:
        begin
          if (ln_q.cnt < `SEE_LAST_BIT)
          begin
            ln_d.sh = byte_v; // R4
            ln_d.cnt = ln_q.cnt + 4'h1;
          end
          else if (ln_q.cnt == `SEE_LAST_BIT)
          begin
            ln_d.sh = byte_v;
            ln_d.cnt = `SEE_ACK_BIT;
            ln_d.drv = 1'b1; // R4
            if (ln_q.st == see_pkg::SEE_S_ADDR)
            begin
              // busy writing: inputs are off, so polling sees no ack
              if (byte_v[7:4] != `SEE_DEV_TYPE || lk_busy ||
                !cs_match(lk_dens, byte_v[3:1], lk_cs)) // R5 R13 R17
              begin
                ln_d.st = see_pkg::SEE_S_IDLE; // R11
                ln_d.cnt = 4'h0;
                ln_d.drv = 1'b0;
              end
              ln_d.rw = byte_v[0]; // R10
              ln_d.pg = byte_v[3:1];
            end
            else if (ln_q.st == see_pkg::SEE_S_WORD)
            begin
              ln_d.ctr = addr_load(lk_dens, ln_q.pg, byte_v); // R12
            end
            else
            begin
              // hand the byte to the system side, then step within page
              ln_d.waddr = ln_q.ctr;
              ln_d.wdata = byte_v;
              ln_d.wtgl = !ln_q.wtgl; // R12 R15
              ln_d.ctr = page_next(lk_dens, ln_q.ctr); // R16 R18
            end
          end
          else
          begin
            // end of the ack clock: let go of sda
            ln_d.drv = 1'b0;
            ln_d.cnt = 4'h0;
            if (ln_q.st == see_pkg::SEE_S_ADDR)
            begin
              if (ln_q.rw)
                load = 1'b1; // R20
              else
                ln_d.st = see_pkg::SEE_S_WORD;
            end
            else
              ln_d.st = see_pkg::SEE_S_WDATA; // R15
          end
        end
        see_pkg::SEE_S_RDATA:
        begin
          if (ln_q.cnt < `SEE_LAST_BIT)
          begin
            ln_d.sh = {ln_q.sh[6:0], 1'b0};
            ln_d.drv = !ln_q.sh[6]; // R3
            ln_d.cnt = ln_q.cnt + 4'h1;
          end
          else if (ln_q.cnt == `SEE_LAST_BIT)
          begin
            ln_d.drv = 1'b0; // R23
            ln_d.cnt = `SEE_ACK_BIT;
          end
          else if (!sda_rise_q)
            load = 1'b1; // R22
          else
          begin
            ln_d.st = see_pkg::SEE_S_HOLD; // R22 R23
            ln_d.cnt = 4'h0;
          end
        end
      endcase
    end
    // next read byte: data of the counter, counter moves one on
    if (load)
    begin
      ln_d.st = see_pkg::SEE_S_RDATA;
      ln_d.cnt = 4'h0;
      ln_d.sh = lk_rdata; // R20 R22
      ln_d.drv = !lk_rdata[7];
      ln_d.ctr = read_next(lk_dens, ln_q.ctr); // R18 R19
    end
  end

  // async assert: the serial clock may not run while reset is held
  always_ff @(negedge link.scl or negedge rst_b_in)
  begin
    if (!rst_b_in)
    begin
      ln_q <= '0;
      ln_q.st <= see_pkg::SEE_S_IDLE;
      ln_q.drv <= `SEE_DRV_RST;
    end
    else
      ln_q <= ln_d;
  end

  assign link.d_sda_out = 1'b0;
  assign link.d_sda_oe = ln_q.drv; // R4
  assign mem_addr_out = ln_q.ctr;

  // link levels and the write toggle brought onto the system clock
  see_sync #(.W(3)) u_sy_sync (
    .clk_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .d_in({link.scl, link.sda, ln_q.wtgl}),
    .q_out(sy_s)
  );

  // the stop has no falling scl edge after it, so this side sees it
  assign stop_v = sy_s[2] && sy_q.sclp && !sy_q.sdap && sy_s[1]; // R2
  assign start_v = sy_s[2] && sy_q.sclp && sy_q.sdap && !sy_s[1]; // R1

  // write strobe and self-timed write interval
  always_comb
  begin
    sy_d = sy_q;
    sy_d.sclp = sy_s[2];
    sy_d.sdap = sy_s[1];
    sy_d.tglp = sy_s[0];
    sy_d.we = (sy_s[0] != sy_q.tglp);
    // write address and data stay still for nine serial clocks after the toggle
    if (sy_s[0] != sy_q.tglp)
    begin
      sy_d.wa = ln_q.waddr;
      sy_d.wd = ln_q.wdata;
    end
    if (sy_q.busy)
    begin
      sy_d.tmr = sy_q.tmr - 18'h00001;
      if (sy_q.tmr == 18'h00000)
        sy_d.busy = 1'b0; // R17
    end
    if (start_v)
      sy_d.wrote = 1'b0;
    if (stop_v && sy_q.wrote)
    begin
      sy_d.busy = 1'b1; // R13
      sy_d.tmr = 18'(TWR_CYC - 1);
      sy_d.wrote = 1'b0;
    end
    // a new byte wins over any clear in the same cycle
    if (sy_q.we)
      sy_d.wrote = 1'b1;
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
      sy_q <= '0;
    else
      sy_q <= sy_d;
  end

  assign mem_we_out = sy_q.we;
  assign mem_waddr_out = sy_q.wa;
  assign mem_wdata_out = sy_q.wd;
  assign busy_out = sy_q.busy;
endmodule : see_dev
`default_nettype wire

//--- rtl/see_mst.sv
// master end: start, byte write, byte read and stop primitives on the link
`timescale 1ns/1ps
`default_nettype none
`include "see_cfg.svh"
module see_mst (
  input wire logic clk_sys_in, // system clock, 50 mhz
  input wire logic rst_b_in, // reset, active low
  see_if.master link, // two-wire link
  input wire logic cmd_valid_in, // command offered
  output logic cmd_ready_out, // command taken when valid and ready
  input wire see_pkg::see_op_t cmd_op_in, // start, write, read or stop
  input wire logic [7:0] cmd_data_in, // byte to send after start or on write
  input wire logic cmd_nack_in, // read: answer no-ack instead of ack
  output logic rsp_valid_out, // one-cycle answer pulse
  output logic [7:0] rsp_data_out, // byte seen on the link
  output logic rsp_nack_out // ninth bit seen, high for no-ack
);
  see_pkg::see_mstate_t m_q;
  see_pkg::see_mstate_t m_d;
  logic sda_s;
  logic tick;

  // sda arrives from the wire, two flops before use
  see_sync #(.W(1)) u_sda_sync (
    .clk_in(clk_sys_in),
    .rst_b_in(rst_b_in),
    .d_in(link.sda),
    .q_out(sda_s)
  );

  assign tick = (m_q.qc == 6'(`SEE_QTR_CYC - 1));

  // quarter-period sequencer; sda only moves while scl is low, except at the start and stop edges
  always_comb
  begin
    m_d = m_q;
    m_d.rv = 1'b0;
    m_d.qc = tick ? 6'h00 : m_q.qc + 6'h01;
    if (tick && m_q.st != see_pkg::SEE_M_IDLE)
      m_d.ph = m_q.ph + 2'h1;
    unique case (m_q.st)
      see_pkg::SEE_M_IDLE:
      begin
        m_d.qc = 6'h00;
        m_d.ph = 2'h0;
        m_d.bn = 4'h0;
        if (cmd_valid_in)
        begin
          unique case (cmd_op_in)
            see_pkg::SEE_OP_START:
            begin
              m_d.st = see_pkg::SEE_M_START;
              m_d.sh = {cmd_data_in, 1'b1}; // R5
            end
            see_pkg::SEE_OP_WRITE:
            begin
              m_d.st = see_pkg::SEE_M_BIT;
              m_d.sh = {cmd_data_in, 1'b1}; // R12
            end
            see_pkg::SEE_OP_READ:
            begin
              m_d.st = see_pkg::SEE_M_BIT;
              m_d.sh = {8'hff, cmd_nack_in}; // R20 R22
            end
            see_pkg::SEE_OP_STOP:
              m_d.st = see_pkg::SEE_M_STOP;
          endcase
        end
      end
      see_pkg::SEE_M_START:
      begin
        // release, raise scl, pull sda low, drop scl: works idle or repeated
        if (tick)
        begin
          unique case (m_q.ph)
            2'h0: m_d.sdl = 1'b0;
            2'h1: m_d.scl = 1'b1;
            2'h2: m_d.sdl = 1'b1; // R1 R21
            2'h3:
            begin
              m_d.scl = 1'b0;
              m_d.st = see_pkg::SEE_M_BIT;
            end
          endcase
        end
      end
      see_pkg::SEE_M_BIT:
      begin
        if (tick)
        begin
          unique case (m_q.ph)
            2'h0: m_d.sdl = !m_q.sh[8]; // R3
            2'h1: m_d.scl = 1'b1;
            2'h2: m_d.rx = {m_q.rx[7:0], sda_s};
            2'h3:
            begin
              m_d.scl = 1'b0;
              m_d.sh = {m_q.sh[7:0], 1'b1};
              m_d.bn = m_q.bn + 4'h1;
              if (m_q.bn == `SEE_ACK_BIT)
              begin
                // sda kept: letting go with the falling clock races start detection
                m_d.rv = 1'b1; // R3 R4
                m_d.rd = m_q.rx[8:1];
                m_d.nk = m_q.rx[0];
                m_d.bn = 4'h0;
                m_d.st = see_pkg::SEE_M_IDLE;
              end
            end
          endcase
        end
      end
      see_pkg::SEE_M_STOP:
      begin
        if (tick)
        begin
          unique case (m_q.ph)
            2'h0: m_d.sdl = 1'b1;
            2'h1: m_d.scl = 1'b1;
            2'h2: m_d.sdl = 1'b0; // R2
            2'h3:
            begin
              m_d.rv = 1'b1;
              m_d.nk = 1'b0;
              m_d.st = see_pkg::SEE_M_IDLE;
            end
          endcase
        end
      end
    endcase
  end

  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      m_q <= '0;
      m_q.st <= see_pkg::SEE_M_IDLE;
      m_q.scl <= `SEE_SCL_RST;
      m_q.sdl <= `SEE_DRV_RST;
    end
    else
      m_q <= m_d;
  end

  assign cmd_ready_out = (m_q.st == see_pkg::SEE_M_IDLE);
  assign rsp_valid_out = m_q.rv;
  assign rsp_data_out = m_q.rd;
  assign rsp_nack_out = m_q.nk;
  assign link.scl = m_q.scl;
  assign link.m_sda_out = 1'b0;
  assign link.m_sda_oe = m_q.sdl;
endmodule : see_mst
`default_nettype wire

//--- test/see_link_chk.sv
// assertions on the link and write strobes of the eeprom master and device pair
`timescale 1ns/1ps
`default_nettype none
module see_link_chk #(
  parameter int TWR_CYC = 250000
) (
  input wire logic clk_sys_in, // system clock
  input wire logic rst_b_in, // reset, active low
  input wire logic scl, // serial clock
  input wire logic m_sda_oe, // master pulls data low
  input wire logic d_sda_oe, // device pulls data low
  input wire logic sda, // resolved data line
  input wire logic busy_out, // self-timed write running
  input wire logic mem_we_out // array write strobe
);
  logic scl_q;
  logic sda_q;
  logic [3:0] since_stop_q;
  logic [7:0] run_q;
  logic [19:0] busy_len_q;
  logic stop_ev;
  // stop seen as data rising while the clock stays high
  assign stop_ev = scl && scl_q && sda && !sda_q;
  // stop and clock-phase counters saturate so long idle stretches stay harmless; the busy length counter restarts whenever busy is low
  always_ff @(posedge clk_sys_in)
  begin
    if (!rst_b_in)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
      since_stop_q <= 4'hf;
      run_q <= 8'hff;
      busy_len_q <= 20'h0;
    end
    else
    begin
      scl_q <= scl;
      sda_q <= sda;
      since_stop_q <= stop_ev ? 4'h0 : (since_stop_q == 4'hf ? 4'hf : since_stop_q + 4'h1);
      run_q <= (scl != scl_q) ? 8'h0 : (run_q == 8'hff ? 8'hff : run_q + 8'h1);
      busy_len_q <= busy_out ? busy_len_q + 20'h1 : 20'h0;
    end
  end
  default clocking cb @(posedge clk_sys_in);
  endclocking
  default disable iff (!rst_b_in);
  property p_dev_steady;
    scl && scl_q |-> $stable(d_sda_oe);
  endproperty
  a_dev_steady: assert property (p_dev_steady) else $error("device data moved with clock high");
  property p_start_clocks;
    scl && scl_q && $rose(m_sda_oe) |-> ##[1:100] !scl;
  endproperty
  a_start_clocks: assert property (p_start_clocks) else $error("no clock after start");
  property p_phase_len;
    (scl != scl_q) |-> run_q >= 8'd56;
  endproperty
  a_phase_len: assert property (p_phase_len) else $error("serial clock phase too short");
  property p_busy_after_stop;
    $rose(busy_out) |-> since_stop_q <= 4'd8;
  endproperty
  a_busy_after_stop: assert property (p_busy_after_stop) else $error("busy without stop");
  property p_busy_len;
    $fell(busy_out) |-> int'(busy_len_q) >= TWR_CYC - 1 && int'(busy_len_q) <= TWR_CYC + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("write interval length wrong");
  property p_quiet_busy;
    busy_out |-> !d_sda_oe;
  endproperty
  a_quiet_busy: assert property (p_quiet_busy) else $error("device answered while busy");
  property p_we_pulse;
    mem_we_out |=> !mem_we_out;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("write strobe longer than one");
  property p_no_we_busy;
    busy_out |-> !mem_we_out;
  endproperty
  a_no_we_busy: assert property (p_no_we_busy) else $error("array write while busy");
  c_busy: cover property ($rose(busy_out));
  c_dev_ack: cover property ($rose(scl) && d_sda_oe);
  c_stop: cover property (stop_ev);
endmodule : see_link_chk
`default_nettype wire

//--- test/tb_serial_eeprom_command_engine.sv
// self-checking bench: master and eeprom device joined across the link
`timescale 1ns/1ps
`default_nettype none
module tb_serial_eeprom_command_engine;
  // short write interval so a poll sees both refusal and answer
  localparam int SELF_TIMED_WRITE_INTERVAL = 3000;
  localparam see_pkg::see_op_t OP_ST = see_pkg::SEE_OP_START;
  localparam see_pkg::see_op_t OP_WR = see_pkg::SEE_OP_WRITE;
  localparam see_pkg::see_op_t OP_RD = see_pkg::SEE_OP_READ;
  localparam see_pkg::see_op_t OP_SP = see_pkg::SEE_OP_STOP;
  typedef struct packed {
    see_pkg::see_dens_t dens;
    logic [2:0] pins;
    logic [7:0] word;
    logic nk;
  } see_row_t;
  // strap setting, device word, expected no-ack
  see_row_t rows [8] = '{'{see_pkg::SEE_D2K, 3'h5, 8'haa, 1'b0},
    '{see_pkg::SEE_D2K, 3'h5, 8'ha8, 1'b1}, '{see_pkg::SEE_D4K, 3'h4, 8'haa, 1'b0},
    '{see_pkg::SEE_D4K, 3'h4, 8'hac, 1'b1}, '{see_pkg::SEE_D8K, 3'h4, 8'hae, 1'b0},
    '{see_pkg::SEE_D8K, 3'h4, 8'ha2, 1'b1}, '{see_pkg::SEE_D16K, 3'h0, 8'hae, 1'b0},
    '{see_pkg::SEE_D16K, 3'h0, 8'hba, 1'b1}};
  logic clk_sys_in = 1'b0;
  logic rst_b_in = 1'b0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  see_pkg::see_op_t cmd_op = OP_SP;
  logic [7:0] cmd_data = 8'h00;
  logic cmd_nack = 1'b0;
  logic rsp_valid;
  logic rsp_nack;
  logic [7:0] rsp_data;
  see_pkg::see_dens_t dens = see_pkg::SEE_D2K;
  logic [2:0] pins = 3'h5;
  logic [7:0] mem [0:2047];
  logic [10:0] maddr;
  logic [10:0] mwaddr;
  logic [7:0] mwdata;
  logic mwe;
  logic busy;
  int fail_count = 0;
  int cmp_count = 0;
  always #10 clk_sys_in = ~clk_sys_in;
  see_if i_see_if();
  see_mst i_see_mst(.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in), .link(i_see_if),
    .cmd_valid_in(cmd_valid), .cmd_ready_out(cmd_ready), .cmd_op_in(cmd_op),
    .cmd_data_in(cmd_data), .cmd_nack_in(cmd_nack), .rsp_valid_out(rsp_valid),
    .rsp_data_out(rsp_data), .rsp_nack_out(rsp_nack));
  see_dev #(.TWR_CYC(SELF_TIMED_WRITE_INTERVAL)) i_see_dev(.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .link(i_see_if), .density_in(dens), .chip_select_pin_two_in(pins[2]),
    .chip_select_pin_one_in(pins[1]), .chip_select_pin_zero_in(pins[0]),
    .mem_rdata_in(mem[maddr]), .mem_addr_out(maddr), .mem_we_out(mwe),
    .mem_waddr_out(mwaddr), .mem_wdata_out(mwdata), .busy_out(busy));
  see_link_chk #(.TWR_CYC(SELF_TIMED_WRITE_INTERVAL)) i_see_link_chk(.clk_sys_in(clk_sys_in), .rst_b_in(rst_b_in),
    .scl(i_see_if.scl), .m_sda_oe(i_see_if.m_sda_oe), .d_sda_oe(i_see_if.d_sda_oe),
    .sda(i_see_if.sda), .busy_out(busy), .mem_we_out(mwe));
  // outside array, written by the device strobe
  always @(posedge clk_sys_in)
  begin
    if (mwe === 1'b1)
    begin
      mem[mwaddr] <= mwdata;
    end
  end
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0)
    begin
      $display("*** PASS ***");
    end
    else
    begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : close_out
  task automatic check(input string what, input logic [10:0] exp, input logic [10:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      $display("Error %s expected %h seen %h", what, exp, got);
      fail_count++;
    end
  endtask : check
  // one master primitive; valid held over exactly one taking edge
  task automatic cmd(input see_pkg::see_op_t op, input logic [7:0] d, input logic nk);
    int n;
    n = 0;
    while (cmd_ready !== 1'b1 && n < 8)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    if (cmd_ready !== 1'b1)
    begin
      $display("Error cmd_ready expected 1 seen %b", cmd_ready);
      fail_count++;
    end
    cmd_op = op;
    cmd_data = d;
    cmd_nack = nk;
    cmd_valid = 1'b1;
    @(negedge clk_sys_in);
    cmd_valid = 1'b0;
    while (rsp_valid !== 1'b1 && n < 1500)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    if (n >= 1500)
    begin
      $display("Error answer timeout expected 1 seen 0");
      fail_count++;
      close_out();
    end
  endtask : cmd
  // start plus device word until the device answers
  task automatic poll(output int n);
    logic nk;
    n = 0;
    nk = 1'b1;
    while (nk === 1'b1 && n < 6)
    begin
      cmd(OP_ST, 8'haa, 1'b0);
      nk = rsp_nack;
      cmd(OP_SP, 8'h00, 1'b0);
      n++;
    end
  endtask : poll
  initial
  begin
    int n;
    for (int i = 0; i < 2048; i++)
    begin
      mem[i] = i[7:0] ^ 8'h5a;
    end
    repeat (12) @(negedge clk_sys_in);
    check("scl in reset", 11'h1, {10'h0, i_see_if.scl});
    rst_b_in = 1'b1;
    foreach (rows[i])
    begin
      dens = rows[i].dens;
      pins = rows[i].pins;
      cmd(OP_ST, rows[i].word, 1'b0);
      check("address ack", {10'h0, rows[i].nk}, {10'h0, rsp_nack});
      cmd(OP_SP, 8'h00, 1'b0);
    end
    $display("test address decode done");
    dens = see_pkg::SEE_D2K;
    pins = 3'h5;
    cmd(OP_ST, 8'haa, 1'b0);
    cmd(OP_WR, 8'h10, 1'b0);
    cmd(OP_WR, 8'h3c, 1'b0);
    check("data ack", 11'h0, {10'h0, rsp_nack});
    cmd(OP_SP, 8'h00, 1'b0);
    n = 0;
    while (busy !== 1'b1 && n < 20)
    begin
      @(negedge clk_sys_in);
      n++;
    end
    check("busy after stop", 11'h1, {10'h0, busy});
    check("byte written", 11'h3c, {3'h0, mem[11'h10]});
    poll(n);
    check("polls refused then taken", 11'h1, {10'h0, n > 1 && n < 6});
    $display("test byte write and polling done");
    cmd(OP_ST, 8'haa, 1'b0);
    cmd(OP_WR, 8'h16, 1'b0);
    for (int k = 0; k < 9; k++)
    begin
      cmd(OP_WR, 8'h80 + k[7:0], 1'b0);
      check("page byte ack", 11'h0, {10'h0, rsp_nack});
    end
    cmd(OP_SP, 8'h00, 1'b0);
    poll(n);
    for (int k = 1; k < 9; k++)
    begin
      check("page wrap", {3'h0, 8'h80 + k[7:0]}, {3'h0, mem[11'h10 + (6 + k) % 8]});
    end
    check("next page kept", 11'h42, {3'h0, mem[11'h18]});
    cmd(OP_ST, 8'hab, 1'b0);
    cmd(OP_RD, 8'h00, 1'b1);
    check("current read", 11'h81, {3'h0, rsp_data});
    cmd(OP_SP, 8'h00, 1'b0);
    $display("test page write and current read done");
    cmd(OP_ST, 8'haa, 1'b0);
    cmd(OP_WR, 8'hff, 1'b0);
    cmd(OP_ST, 8'hab, 1'b0);
    cmd(OP_RD, 8'h00, 1'b0);
    check("random read", 11'ha5, {3'h0, rsp_data});
    cmd(OP_RD, 8'h00, 1'b1);
    check("read wrap", 11'h5a, {3'h0, rsp_data});
    cmd(OP_SP, 8'h00, 1'b0);
    dens = see_pkg::SEE_D16K;
    cmd(OP_ST, 8'hae, 1'b0);
    cmd(OP_WR, 8'h34, 1'b0);
    cmd(OP_ST, 8'haf, 1'b0);
    cmd(OP_RD, 8'h00, 1'b1);
    check("paged random read", 11'h6e, {3'h0, rsp_data});
    cmd(OP_SP, 8'h00, 1'b0);
    $display("test random and sequential read done");
    rst_b_in = 1'b0;
    repeat (12) @(negedge clk_sys_in);
    check("scl idle in reset", 11'h1, {10'h0, i_see_if.scl});
    check("sda free in reset", 11'h1, {10'h0, i_see_if.sda});
    check("ready in reset", 11'h1, {10'h0, cmd_ready});
    rst_b_in = 1'b1;
    cmd(OP_ST, 8'haa, 1'b0);
    check("ack after reset", 11'h0, {10'h0, rsp_nack});
    cmd(OP_SP, 8'h00, 1'b0);
    $display("test mid-run reset done");
    close_out();
  end
endmodule : tb_serial_eeprom_command_engine
`default_nettype wire
